/* verilog/ivm_pkg.sv */
// constants, vector table and carrier types of the interrupt vector map
// assumes a 16-bit program word address space and a core that fetches vectors
//
// How it works
// - every reset source goes to word 0x0000 unless the boot fuse redirects
// - external request lines 0..7 use vectors 0x0002 to 0x0010, two apart
// - timer 2 compare at 0x0012, overflow at 0x0014
// - timer 1 capture 0x0016, compares 0x0018..0x001c, overflow 0x001e
// - timer 0 compare at 0x0020, overflow at 0x0022
// - can general event at 0x0024, can timer overrun at 0x0026
// - serial peripheral transfer complete at 0x0028
// - first usart receive 0x002a, buffer empty 0x002c, transmit 0x002e
// - comparator 0x0030, conversion complete 0x0032, eeprom ready 0x0034
// - timer 3 capture 0x0036, compares 0x0038..0x003c, overflow 0x003e
// - second usart receive 0x0040, buffer empty 0x0042, transmit 0x0044
// - two-wire serial at 0x0046, self-write ready 0x0048 ends the table
// - relocation set adds the boot section start to every interrupt vector
// - programmed boot fuse starts execution at the boot reset address
// - fuse 1 gives reset 0x0000, else boot address; table base moves only with relocation select
// - relocation select is control bit 1 and resets to zero
`default_nettype none
package ivm_pkg;
  // ****************************************
  // sizes and control bits
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int IRQ_COUNT = 36;
  localparam int NUM_W = 6;
  localparam int CTRL_W = 8;
  localparam int CTRL_RELOC_BIT = 1;
  localparam logic CTRL_RELOC_RST = 1'h0;
  localparam logic FUSE_UNPROGRAMMED = 1'h1;
  localparam logic [NUM_W-1:0] FIRST_IRQ_NUM = 6'h02;

  // ****************************************
  // vector addresses, in table order
  // ****************************************
  localparam logic [ADDR_W-1:0] VEC_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] VEC_ADDR [IRQ_COUNT] = '{
    16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010,
    16'h0012, 16'h0014,
    16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e,
    16'h0020, 16'h0022,
    16'h0024, 16'h0026,
    16'h0028,
    16'h002a, 16'h002c, 16'h002e,
    16'h0030, 16'h0032, 16'h0034,
    16'h0036, 16'h0038, 16'h003a, 16'h003c, 16'h003e,
    16'h0040, 16'h0042, 16'h0044,
    16'h0046, 16'h0048
  };

  // ****************************************
  // carrier toward the core
  // ****************************************
  typedef struct packed {
    logic active;
    logic [NUM_W-1:0] num;
    logic [ADDR_W-1:0] addr;
  } ivm_vec_s;
endpackage
`default_nettype wire

/* verilog/ivm_vector_map.sv */
// reset and interrupt vector address generator
// assumes request lines are synchronous, already enabled and masked upstream;
// the boot section start comes from fuse decoding outside this block
`timescale 1ns/10ps
`default_nettype none
module ivm_vector_map #(
  parameter int IRQS = ivm_pkg::IRQ_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // pending requests, bit 0 is vector number 2
  input wire logic [IRQS-1:0] irqPend,
  // fuse and boot section
  input wire logic bootResetFuse,
  input wire logic [ivm_pkg::ADDR_W-1:0] bootResetAddr,
  // control register write
  input wire logic ctrlWrEn,
  input wire logic [ivm_pkg::CTRL_W-1:0] ctrlWrData,
  // toward the core
  output logic [ivm_pkg::ADDR_W-1:0] resetVector,
  output ivm_pkg::ivm_vec_s irqOut,
  output logic vectorRelocateSelect
);

  // ****************************************
  // state
  // ****************************************
  logic relocate_r;
  logic [ivm_pkg::ADDR_W-1:0] resetVec_r;
  ivm_pkg::ivm_vec_s irq_r;
  ivm_pkg::ivm_vec_s irqNxt;

  // ****************************************
  // priority selection
  // ****************************************
  logic [IRQS:0] blocked;
  logic [IRQS-1:0] winner;
  logic [ivm_pkg::NUM_W-1:0] idxChain [IRQS+1];

  assign blocked[0] = 1'b0;
  assign idxChain[0] = '0;

  // a lower index blocks every higher one, so the lowest number wins
  genvar gi;
  generate
    for (gi = 0; gi < IRQS; gi++) begin : g_prio
      assign winner[gi] = irqPend[gi] & ~blocked[gi];
      assign blocked[gi+1] = blocked[gi] | irqPend[gi];
      assign idxChain[gi+1] = idxChain[gi] | (winner[gi] ? ivm_pkg::NUM_W'(gi) : '0);
    end
  endgenerate

  // ****************************************
  // address forming
  // ****************************************
  wire anyPend = blocked[IRQS];
  wire [ivm_pkg::NUM_W-1:0] winIdx = idxChain[IRQS];
  wire [ivm_pkg::ADDR_W-1:0] tableAddr = ivm_pkg::VEC_ADDR[winIdx];
  // table entries above also cover the later groups
  wire [ivm_pkg::ADDR_W-1:0] relocAddr = ivm_pkg::ADDR_W'(tableAddr + bootResetAddr);
  // table base follows relocation; reset target follows the fuse
  wire [ivm_pkg::ADDR_W-1:0] irqAddr = relocate_r ? relocAddr : tableAddr;
  wire [ivm_pkg::ADDR_W-1:0] resetNxt = (bootResetFuse == ivm_pkg::FUSE_UNPROGRAMMED) ?
    ivm_pkg::VEC_RESET : bootResetAddr;
  wire relocNxt = ctrlWrEn ? ctrlWrData[ivm_pkg::CTRL_RELOC_BIT] : relocate_r;

  // carrier assembled combinationally, registered below
  always_comb begin
    irqNxt.active = anyPend;
    irqNxt.num = anyPend ? ivm_pkg::NUM_W'(winIdx + ivm_pkg::FIRST_IRQ_NUM) : '0;
    irqNxt.addr = anyPend ? irqAddr : '0;
  end

  // ****************************************
  // registers
  // ****************************************
  // relocation bit; a timed unlock sequence belongs to the writer, not here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relocate_r <= ivm_pkg::CTRL_RELOC_RST;
    end else if (clkEn) begin
      relocate_r <= relocNxt;
    end
  end

  // reset target follows the fuse level; a fuse change is seen one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resetVec_r <= ivm_pkg::VEC_RESET;
    end else if (clkEn) begin
      resetVec_r <= resetNxt;
    end
  end

  // registered vector keeps the core path off the priority chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= '0;
    end else if (clkEn) begin
      irq_r <= irqNxt;
    end
  end

  assign resetVector = resetVec_r;
  assign irqOut = irq_r;
  assign vectorRelocateSelect = relocate_r;

  // ****************************************
  // checks
  // ****************************************
  // the release edge itself still resets, so the sampled rst keeps attempts there out
  sequence s_ext0_only;
    !rst && clkEn && irqPend == IRQS'(1) && !relocate_r && !ctrlWrEn;
  endsequence

  sequence s_ext7_only;
    !rst && clkEn && irqPend == IRQS'(8'h80) && !relocate_r && !ctrlWrEn;
  endsequence

  property p_reset_zero;
    @(posedge clk) disable iff (rst)
      clkEn && bootResetFuse |=> resetVector == 16'h0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset vector not zero with fuse clear");

  property p_boot_reset;
    @(posedge clk) disable iff (rst)
      !rst && clkEn && !bootResetFuse |=> resetVector == $past(bootResetAddr);
  endproperty
  a_boot_reset: assert property (p_boot_reset) else $error("reset vector not boot address");

  property p_ext_first;
    @(posedge clk) disable iff (rst)
      s_ext0_only |=> irqOut.active && irqOut.addr == 16'h0002 && irqOut.num == 6'h02;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("line 0 vector wrong");

  property p_ext_last;
    @(posedge clk) disable iff (rst)
      s_ext7_only |=> irqOut.addr == 16'h0010;
  endproperty
  a_ext_last: assert property (p_ext_last) else $error("line 7 vector wrong");

  property p_table_end;
    @(posedge clk) disable iff (rst)
      !rst && clkEn && irqPend == {1'b1, {(IRQS-1){1'b0}}} && !relocate_r |=> irqOut.addr == 16'h0048;
  endproperty
  a_table_end: assert property (p_table_end) else $error("self-write vector wrong");

  property p_spi;
    @(posedge clk) disable iff (rst)
      !rst && clkEn && irqPend == (IRQS'(1) << 19) && !relocate_r |=> irqOut.addr == 16'h0028;
  endproperty
  a_spi: assert property (p_spi) else $error("serial peripheral vector wrong");

  property p_reloc;
    @(posedge clk) disable iff (rst)
      !rst && clkEn && relocate_r && irqPend[0] |=>
        irqOut.addr == 16'($past(bootResetAddr) + 16'h0002);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocated vector wrong");

  property p_prio;
    @(posedge clk) disable iff (rst)
      !rst && clkEn && irqPend[3] && irqPend[20] && irqPend[2:0] == 3'h0 |=> irqOut.num == 6'h05;
  endproperty
  a_prio: assert property (p_prio) else $error("lower number did not win");

  property p_reloc_write;
    @(posedge clk) disable iff (rst)
      clkEn && ctrlWrEn ##1 !ctrlWrEn [*2] |-> vectorRelocateSelect == $past(ctrlWrData[1], 2);
  endproperty
  a_reloc_write: assert property (p_reloc_write) else $error("relocation bit not held");

  property p_idle;
    @(posedge clk) disable iff (rst)
      clkEn && irqPend == '0 |=> !irqOut.active && irqOut.addr == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("vector active with nothing pending");

endmodule // ivm_vector_map
`default_nettype wire

/* tb/ivm_core_model.sv */
// core side: fetches the reset target, or the vector of a pending request
// assumes the map's registered outputs and the same clock and reset
`timescale 1ns/10ps
`default_nettype none
module ivm_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // from the map
  input wire ivm_pkg::ivm_vec_s irqOut,
  input wire logic [15:0] resetVector,
  // fetch address toward program memory
  output logic [15:0] fetchAddr
);
  // ****************************************
  // vector fetch
  // ****************************************
  // fetches every cycle with no accept delay, so the map's earliest answer is used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetchAddr <= 16'h0000;
    end else if (irqOut.active) begin
      fetchAddr <= irqOut.addr;
    end else begin
      fetchAddr <= resetVector;
    end
  end
endmodule // ivm_core_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the vector map with a core model on its output
// assumes one 25 MHz clock and the one-cycle answer latency of the map
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic clkEn = 1'h1;
  logic bootResetFuse = 1'h1;
  logic ctrlWrEn = 1'h0;
  logic [7:0] ctrlWrData = 8'h00;
  logic [35:0] irqPend = '0;
  logic [15:0] bootResetAddr = 16'h0000;
  logic [15:0] resetVector;
  logic [15:0] fetchAddr;
  ivm_pkg::ivm_vec_s irqOut;
  ivm_pkg::ivm_vec_s held;
  logic vectorRelocateSelect;
  logic relocExp = 1'h0;
  int mismatches = 0;
  int tests_run = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  ivm_vector_map ivm_vector_map_i (.clk(clk), .rst(rst), .clkEn(clkEn), .irqPend(irqPend),
    .bootResetFuse(bootResetFuse), .bootResetAddr(bootResetAddr), .ctrlWrEn(ctrlWrEn),
    .ctrlWrData(ctrlWrData), .resetVector(resetVector), .irqOut(irqOut),
    .vectorRelocateSelect(vectorRelocateSelect));
  ivm_core_model ivm_core_model_i (.clk(clk), .rst(rst), .irqOut(irqOut),
    .resetVector(resetVector), .fetchAddr(fetchAddr));

  // ****************************************
  // expectations and bus steps
  // ****************************************
  // vectors sit two words apart from 0x0002; relocation adds the boot start, 16-bit wrap
  function automatic logic [22:0] expVec(input int i);
    logic [15:0] a;
    a = 16'(2 * i + 2) + (relocExp ? bootResetAddr : 16'h0000);
    return {1'h1, 6'(i + 2), a};
  endfunction

  // lowest numbered pending source wins; idle is all zero
  function automatic logic [22:0] expPend(input logic [35:0] v);
    logic [22:0] r;
    r = '0;
    for (int i = 35; i >= 0; i--) begin
      if (v[i]) r = expVec(i);
    end
    return r;
  endfunction

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic drive(input logic [35:0] v, input logic f, input logic [15:0] b);
    @(posedge clk);
    irqPend <= v;
    bootResetFuse <= f;
    bootResetAddr <= b;
    @(posedge clk);
    @(negedge clk);
    chk(23'(resetVector), f ? 23'h0 : 23'(b));
    chk(irqOut, expPend(v));
  endtask

  task automatic wrCtrl(input logic [7:0] d);
    @(posedge clk);
    ctrlWrEn <= 1'h1;
    ctrlWrData <= d;
    @(posedge clk);
    ctrlWrEn <= 1'h0;
    @(negedge clk);
    relocExp = d[1];
    chk(23'(vectorRelocateSelect), 23'(d[1]));
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hd448));
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk({vectorRelocateSelect, irqOut[21:0]}, 23'h0);
    chk(23'({irqOut.active, resetVector}), 23'h0);
    @(posedge clk);
    rst <= 1'h0;
    // each source alone at its table place, then fetched by the core
    for (int i = 0; i < 36; i++) begin
      drive(36'h1 << i, 1'h1, 16'h0000);
      @(posedge clk);
      @(negedge clk);
      chk(23'(fetchAddr), expVec(i) & 23'hffff);
    end
    // corner: every source pending, table moved so far that it wraps
    wrCtrl(8'hff);
    drive('1, 1'h0, 16'hfffe);
    // corner: two sources far apart, the lower one must win while relocated
    drive(36'h000100008, 1'h1, 16'h1000);
    // random mixes, both fuse settings, table moved and back with junk in other bits
    for (int k = 0; k < 120; k++) begin
      if (k % 40 == 0) wrCtrl(8'($urandom) & 8'hfd);
      if (k % 40 == 20) wrCtrl(8'($urandom) | 8'h02);
      drive((k % 7 == 0) ? 36'h0 : {4'($urandom), 32'($urandom)} & {4'($urandom), 32'($urandom)},
        1'($urandom), 16'($urandom));
    end
    // enable low freezes outputs and ignores a control write and a fuse change
    held = irqOut;
    @(posedge clk);
    clkEn <= 1'h0;
    irqPend <= ~irqPend;
    ctrlWrEn <= 1'h1;
    ctrlWrData <= {6'h00, ~relocExp, 1'h0};
    bootResetFuse <= ~bootResetFuse;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irqOut, held);
    chk(23'(vectorRelocateSelect), 23'(relocExp));
    chk(23'(resetVector), bootResetFuse ? 23'(bootResetAddr) : 23'h0);
    @(posedge clk);
    clkEn <= 1'h1;
    ctrlWrEn <= 1'h0;
    // second reset mid-run clears relocation
    wrCtrl(8'h02);
    @(posedge clk);
    rst <= 1'h1;
    @(negedge clk);
    chk({vectorRelocateSelect, irqOut[21:0]}, 23'h0);
    chk(23'({irqOut.active, resetVector}), 23'h0);
    @(posedge clk);
    rst <= 1'h0;
    relocExp = 1'h0;
    drive(36'h800000000, 1'h1, 16'h7000);
    results();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // testbench
`default_nettype wire
